// File: include/ptx_cfg.svh
// offsets, field positions, reset values and the indexed window bounds
`ifndef PTX_CFG_SVH
`define PTX_CFG_SVH
`define PTX_OFS_DOMVER     16'h0518
`define PTX_OFS_UNITIDX    16'h0520
`define PTX_OFS_TRIGSTAT   16'h0524
`define PTX_OFS_MSGCFG     16'h0514
`define PTX_WIN_LO         16'h052c
`define PTX_WIN_HI         16'h05b3
`define PTX_VER_RST        4'h2
`define PTX_DOM_RST        8'h00
`define PTX_VER_LSB        8
`define PTX_STAMP_BIT      8
`define PTX_ERR_LSB        16
`define PTX_DOMCHK_BIT     4
`endif

// File: include/ptx_pkg.sv
// types for the timing index and trigger status bank
package ptx_pkg;
  typedef struct packed {
    logic [3:0] version;
    logic [7:0] domain;
    logic       domChk;
    logic       stampSel;
    logic [1:0] fireSel;
    logic [2:0] trigErr;
    logic [2:0] trigDone;
    logic [31:0] rdData;
    logic       rdValid;
  } ptx_state_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] version;
    logic [7:0] domain;
  } ptx_msg_t;
  typedef struct packed {
    logic       capture;
    logic       toHost;
    logic       drop;
  } ptx_verdict_t;
endpackage : ptx_pkg

// File: rtl/ptx_index_status.sv
// timing domain/version filter, unit index pointer and trigger status bank
//
// Summary of operation
// - hold 4-bit version, reset two, capture matches
// - drop messages whose version differs
// - 8-bit domain, reset zero, capture on match
// - domain ignored while domain checking off
// - bit 4 enables domain check, mismatch drops
// - indexed range accesses selected units
// - one index bit selects timestamp unit
// - 2-bit trigger index, code 11 unused
// - late event with notify sets sticky error
// - error clears on enable falling or W1C
// - trigger output with notify sets done
// - writing one clears done, zero keeps
`timescale 1ns/1ps
`include "ptx_cfg.svh"
module ptx_index_status (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // management register access
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  input  wire logic [15:0]          regAddr,
  input  wire logic [31:0]          regWrData,
  output logic      [31:0]          regRdData,
  output logic                      regRdValid,
  // indexed window routing
  output logic                      winHit,
  output logic                      stampUnitSelect,
  output logic      [1:0]           fireUnitSelect,
  // trigger unit events
  input  wire logic [2:0]           fireLate,
  input  wire logic [2:0]           fireGenerated,
  input  wire logic [2:0]           fireNotifyEnable,
  input  wire logic [2:0]           fireEnableFall,
  output logic                      trigIrq,
  // received message check
  input  ptx_pkg::ptx_msg_t         rxMsg,
  output ptx_pkg::ptx_verdict_t     rxVerdict
);

  ptx_pkg::ptx_state_t st;
  ptx_pkg::ptx_state_t next_st;

  // address decode shared by read and write paths
  function automatic logic isAddr(input logic [15:0] a, input logic [15:0] ofs);
    isAddr = (a[15:2] == ofs[15:2]);
  endfunction : isAddr

  // window decode for the indexed unit registers
  assign winHit = (regWr | regRd) && (regAddr >= `PTX_WIN_LO) &&
                  (regAddr <= `PTX_WIN_HI);
  assign stampUnitSelect = st.stampSel;
  assign fireUnitSelect  = st.fireSel;
  assign regRdData  = st.rdData;
  assign regRdValid = st.rdValid;
  assign trigIrq    = |{st.trigErr, st.trigDone};

  // message filter on received timing messages
  always_comb begin
    logic verOk;
    logic domOk;
    verOk = (rxMsg.version == st.version);
    domOk = !st.domChk || (rxMsg.domain == st.domain);
    rxVerdict.capture = rxMsg.valid && verOk && domOk;
    rxVerdict.toHost  = rxMsg.valid && verOk && domOk;
    rxVerdict.drop    = rxMsg.valid && !(verOk && domOk);
  end

  // register writes, sticky status and read mux
  always_comb begin
    logic [2:0] errW1c;
    logic [2:0] doneW1c;
    next_st = st;
    errW1c  = 3'h0;
    doneW1c = 3'h0;
    if (regWr && isAddr(regAddr, `PTX_OFS_DOMVER)) begin
      next_st.version = regWrData[`PTX_VER_LSB +: 4];
      next_st.domain  = regWrData[7:0];
    end
    if (regWr && isAddr(regAddr, `PTX_OFS_MSGCFG)) begin
      next_st.domChk = regWrData[`PTX_DOMCHK_BIT];
    end
    if (regWr && isAddr(regAddr, `PTX_OFS_UNITIDX)) begin
      next_st.stampSel = regWrData[`PTX_STAMP_BIT];
      next_st.fireSel  = regWrData[1:0];
    end
    if (regWr && isAddr(regAddr, `PTX_OFS_TRIGSTAT)) begin
      errW1c  = regWrData[`PTX_ERR_LSB +: 3];
      doneW1c = regWrData[2:0];
    end
    // set wins over clear
    next_st.trigErr  = (st.trigErr & ~errW1c & ~fireEnableFall) |
                       (fireLate & fireNotifyEnable);
    next_st.trigDone = (st.trigDone & ~doneW1c) |
                       (fireGenerated & fireNotifyEnable);
    next_st.rdValid = regRd;
    next_st.rdData  = 32'h0;
    if (regRd) begin
      if (isAddr(regAddr, `PTX_OFS_DOMVER))
        next_st.rdData = {20'h0, st.version, st.domain};
      else if (isAddr(regAddr, `PTX_OFS_MSGCFG))
        next_st.rdData = {27'h0, st.domChk, 4'h0};
      else if (isAddr(regAddr, `PTX_OFS_UNITIDX))
        next_st.rdData = {23'h0, st.stampSel, 6'h0, st.fireSel};
      else if (isAddr(regAddr, `PTX_OFS_TRIGSTAT))
        next_st.rdData = {13'h0, st.trigErr, 13'h0, st.trigDone};
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.version  <= `PTX_VER_RST;
      st.domain   <= `PTX_DOM_RST;
    end else begin
      st <= next_st;
    end
  end

  // filter values must be back at their defaults on the first edge after reset
  verRst_a: assert property (@(posedge clk)
    $fell(rst) |-> st.version == `PTX_VER_RST && st.domain == `PTX_DOM_RST)
    else $error("filter values wrong after reset");

  // a version mismatch drops the message whatever the domain says
  verDrop_a: assert property (@(posedge clk) disable iff (rst)
    rxMsg.valid && rxMsg.version != st.version |->
    rxVerdict.drop && !rxVerdict.capture && !rxVerdict.toHost)
    else $error("mismatched version not dropped");

  // with checking on, a foreign domain never reaches capture
  domMatch_a: assert property (@(posedge clk) disable iff (rst)
    rxMsg.valid && st.domChk && rxMsg.domain != st.domain |->
    rxVerdict.drop && !rxVerdict.capture)
    else $error("mismatched domain passed");

  // with checking on, a full match goes to the host port
  hostRoute_a: assert property (@(posedge clk) disable iff (rst)
    rxMsg.valid && st.domChk && rxMsg.version == st.version &&
    rxMsg.domain == st.domain |-> rxVerdict.toHost && rxVerdict.capture && !rxVerdict.drop)
    else $error("matching domain not sent to host");

  // with checking off only the version decides
  domIgnore_a: assert property (@(posedge clk) disable iff (rst)
    rxMsg.valid && !st.domChk && rxMsg.version == st.version |->
    rxVerdict.capture && !rxVerdict.drop)
    else $error("domain not ignored");

  // window decode at both ends of the indexed range and just past it
  winLow_a: assert property (@(posedge clk) disable iff (rst)
    (regWr || regRd) && regAddr == `PTX_WIN_LO |-> winHit)
    else $error("window start not decoded");
  winHigh_a: assert property (@(posedge clk) disable iff (rst)
    (regWr || regRd) && regAddr == `PTX_WIN_HI |-> winHit)
    else $error("window end not decoded");
  winOut_a: assert property (@(posedge clk) disable iff (rst)
    (regWr || regRd) && regAddr > `PTX_WIN_HI |-> !winHit)
    else $error("window hit past its end");

  // an index write lands one cycle later on the unit selects
  idxWrite_a: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == `PTX_OFS_UNITIDX |=>
    stampUnitSelect == $past(regWrData[`PTX_STAMP_BIT]) &&
    fireUnitSelect == $past(regWrData[1:0]))
    else $error("index write lost");

  // a notified late event raises its error bit and the interrupt
  errSet_a: assert property (@(posedge clk) disable iff (rst)
    (fireLate & fireNotifyEnable) != 3'h0 |=> trigIrq ##0
    ((st.trigErr & $past(fireLate & fireNotifyEnable)) == $past(fireLate & fireNotifyEnable)))
    else $error("error bit not set");

  // a late event without notify leaves a clear error bit clear
  errQuiet_a: assert property (@(posedge clk) disable iff (rst)
    (fireLate & ~fireNotifyEnable & ~st.trigErr) != 3'h0 |=>
    (st.trigErr & $past(fireLate & ~fireNotifyEnable & ~st.trigErr)) == 3'h0)
    else $error("error bit set without notify");

  // enable falling clears the error bit unless a new late event lands with it
  errClr_a: assert property (@(posedge clk) disable iff (rst)
    (fireEnableFall & ~(fireLate & fireNotifyEnable)) != 3'h0 |=>
    (st.trigErr & $past(fireEnableFall & ~(fireLate & fireNotifyEnable))) == 3'h0)
    else $error("error bit not cleared");

  // writing one to an error bit clears it, a same-cycle set still wins
  errW1c_a: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == `PTX_OFS_TRIGSTAT &&
    (regWrData[`PTX_ERR_LSB +: 3] & ~(fireLate & fireNotifyEnable)) != 3'h0 |=>
    (st.trigErr & $past(regWrData[`PTX_ERR_LSB +: 3] & ~(fireLate & fireNotifyEnable))) == 3'h0)
    else $error("error bit not cleared by write");

  // a notified trigger output raises its done bit and the interrupt
  doneSet_a: assert property (@(posedge clk) disable iff (rst)
    (fireGenerated & fireNotifyEnable) != 3'h0 |=> trigIrq ##0
    ((st.trigDone & $past(fireGenerated & fireNotifyEnable)) ==
    $past(fireGenerated & fireNotifyEnable)))
    else $error("done bit not set");

  // writing one clears a done bit unless a new output lands in that cycle
  doneClr_a: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == `PTX_OFS_TRIGSTAT &&
    (regWrData[2:0] & ~(fireGenerated & fireNotifyEnable)) != 3'h0 |=>
    (st.trigDone & $past(regWrData[2:0] & ~(fireGenerated & fireNotifyEnable))) == 3'h0)
    else $error("done bit not cleared by write");

  // writing zero keeps a standing done bit
  doneKeep_a: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == `PTX_OFS_TRIGSTAT |=>
    (st.trigDone & $past(st.trigDone & ~regWrData[2:0])) ==
    $past(st.trigDone & ~regWrData[2:0]))
    else $error("done bit lost on zero write");

  // reserved positions of the status and index words read as zero
  resvRead_a: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == `PTX_OFS_TRIGSTAT |=> regRdValid && regRdData[31:19] == 13'h0 &&
    regRdData[15:3] == 13'h0)
    else $error("reserved bits nonzero");
  idxResv_a: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == `PTX_OFS_UNITIDX |=> regRdValid && regRdData[31:9] == 23'h0 &&
    regRdData[7:2] == 6'h0)
    else $error("reserved index bits nonzero");

  // main scenarios reached
  doneCov_c: cover property (@(posedge clk) disable iff (rst) $rose(st.trigDone[0]));
  errCov_c: cover property (@(posedge clk) disable iff (rst) $fell(st.trigErr[1]));
  winCov_c: cover property (@(posedge clk) disable iff (rst) winHit && st.stampSel);
  dropCov_c: cover property (@(posedge clk) disable iff (rst) rxVerdict.drop && st.domChk);
  setWin_c: cover property (@(posedge clk) disable iff (rst) regWr &&
    regAddr == `PTX_OFS_TRIGSTAT && (regWrData[2:0] & fireGenerated & fireNotifyEnable) != 3'h0);

endmodule : ptx_index_status

// File: sim/ptx_index_status_tb.sv
// self-checking bench for the timing index and trigger status bank
`timescale 1ns/1ps
`include "ptx_cfg.svh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nMismatch++; \
  $display("MISMATCH at %0t: got %0h want %0h", $time, a, b); end end
module ptx_index_status_tb;
  typedef struct packed {
    logic       chk;
    logic [3:0] ver;
    logic [7:0] dom;
    logic       cap;
  } ptx_row_t;
  logic                  clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [15:0]           regAddr = 16'h0000;
  logic [31:0]           regWrData = 32'h0, regRdData;
  logic                  regRdValid, winHit, stampUnitSelect, trigIrq;
  logic [1:0]            fireUnitSelect;
  logic [2:0]            fireLate = 3'h0, fireGenerated = 3'h0;
  logic [2:0]            fireNotifyEnable = 3'h0, fireEnableFall = 3'h0;
  ptx_pkg::ptx_msg_t     rxMsg = '0;
  ptx_pkg::ptx_verdict_t rxVerdict;
  int                    nMismatch = 0, cmpCount = 0, cyc = 0;
  ptx_row_t              rows [5] = '{'{1'b0, 4'h3, 8'h00, 1'b1}, '{1'b0, 4'h2, 8'h5a, 1'b0},
    '{1'b1, 4'h3, 8'h5a, 1'b1}, '{1'b1, 4'h3, 8'h5b, 1'b0}, '{1'b1, 4'h4, 8'h5a, 1'b0}};
  // clock and cycle ceiling
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      nMismatch++;
      giveVerdict();
    end
  end
  ptx_index_status dut_u (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .winHit(winHit), .stampUnitSelect(stampUnitSelect),
    .fireUnitSelect(fireUnitSelect), .fireLate(fireLate), .fireGenerated(fireGenerated),
    .fireNotifyEnable(fireNotifyEnable), .fireEnableFall(fireEnableFall),
    .trigIrq(trigIrq), .rxMsg(rxMsg), .rxVerdict(rxVerdict));
  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask : wr
  // read strobe, window decode check, answer one cycle later
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk);
    regRd = 1'b1;
    regAddr = a;
    #1 `CHK(winHit, (a >= `PTX_WIN_LO && a <= `PTX_WIN_HI))
    @(negedge clk);
    regRd = 1'b0;
    `CHK(regRdValid, 1'b1)
    `CHK(regRdData, e)
  endtask : rd
  // one-cycle event pulse with notify bits
  task automatic ev(input logic [2:0] late, input logic [2:0] gen, input logic [2:0] ntf);
    @(negedge clk);
    fireLate = late;
    fireGenerated = gen;
    fireNotifyEnable = ntf;
    @(negedge clk);
    {fireLate, fireGenerated, fireNotifyEnable} = '0;
  endtask : ev
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(`PTX_OFS_DOMVER, 32'h0000_0200);
    rd(`PTX_OFS_UNITIDX, 32'h0);
    rd(`PTX_OFS_TRIGSTAT, 32'h0);
    // verdict table against stored version 3, domain 5a
    wr(`PTX_OFS_DOMVER, 32'hffff_f35a);
    rd(`PTX_OFS_DOMVER, 32'h0000_035a);
    foreach (rows[i]) begin
      wr(`PTX_OFS_MSGCFG, {27'h0, rows[i].chk, 4'h0});
      rxMsg = '{valid: 1'b1, version: rows[i].ver, domain: rows[i].dom};
      #1 `CHK(rxVerdict, {3{rows[i].cap}} ^ 3'b001)
    end
    // domain check enable with reserved bits set
    wr(`PTX_OFS_MSGCFG, 32'hffff_ffff);
    rd(`PTX_OFS_MSGCFG, 32'h0000_0010);
    // unit index with reserved bits set; the reserved code 11 is never written
    wr(`PTX_OFS_UNITIDX, 32'hffff_ff02);
    rd(`PTX_OFS_UNITIDX, 32'h0000_0102);
    `CHK({stampUnitSelect, fireUnitSelect}, 3'b110)
    // window ends and their neighbours
    rd(`PTX_WIN_LO, 32'h0);
    rd(16'h05b0, 32'h0);
    rd(`PTX_WIN_HI, 32'h0);
    rd(16'h05b4, 32'h0);
    rd(16'h052b, 32'h0);
    rd(16'h0600, 32'h0);
    // sticky done and error only where notify is set
    ev(3'b110, 3'b101, 3'b011);
    `CHK(trigIrq, 1'b1)
    rd(`PTX_OFS_TRIGSTAT, 32'h0002_0001);
    wr(`PTX_OFS_TRIGSTAT, 32'h0);
    rd(`PTX_OFS_TRIGSTAT, 32'h0002_0001);
    wr(`PTX_OFS_TRIGSTAT, 32'hfff8_0001);
    rd(`PTX_OFS_TRIGSTAT, 32'h0002_0000);
    @(negedge clk);
    fireEnableFall = 3'b010;
    @(negedge clk);
    fireEnableFall = 3'b000;
    rd(`PTX_OFS_TRIGSTAT, 32'h0);
    `CHK(trigIrq, 1'b0)
    ev(3'b100, 3'b000, 3'b100);
    wr(`PTX_OFS_TRIGSTAT, 32'h0004_0000);
    rd(`PTX_OFS_TRIGSTAT, 32'h0);
    // done set and write-one clear in the same cycle: the set wins
    @(negedge clk);
    {fireGenerated, fireNotifyEnable} = 6'b001_001;
    {regWr, regAddr, regWrData} = {1'b1, `PTX_OFS_TRIGSTAT, 32'h0000_0001};
    @(negedge clk);
    {fireGenerated, fireNotifyEnable, regWr} = '0;
    rd(`PTX_OFS_TRIGSTAT, 32'h0000_0001);
    `CHK(trigIrq, 1'b1)
    // reset in mid-run drops the standing done bit and restores defaults
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK(trigIrq, 1'b0)
    rd(`PTX_OFS_DOMVER, 32'h0000_0200);
    rd(`PTX_OFS_MSGCFG, 32'h0);
    rd(`PTX_OFS_UNITIDX, 32'h0);
    rd(`PTX_OFS_TRIGSTAT, 32'h0);
    rxMsg = '{valid: 1'b1, version: `PTX_VER_RST, domain: 8'h77};
    #1 `CHK(rxVerdict, 3'b110)
    giveVerdict();
  end
endmodule : ptx_index_status_tb
